// *** rtl/mshl_map.vh ***
// Purpose: Register offsets, field codes and reset values for the motion sequence / homing / limit block
// Assumes: Plain register port, 32-bit data, word offsets
// Notes:   Definitions only
`ifndef MSHL_MAP_VH
`define MSHL_MAP_VH

// Register offsets
`define MSHL_ADDR_CHAIN       8'h00
`define MSHL_ADDR_HOME_MODE   8'h04
`define MSHL_ADDR_LIMIT_START 8'h08
`define MSHL_ADDR_LIMIT_END   8'h0C
`define MSHL_ADDR_FORCE       8'h10
`define MSHL_ADDR_CONTROL     8'h14
`define MSHL_ADDR_STATUS      8'h18
`define MSHL_ADDR_HOME_POS    8'h1C

// Chaining options
`define MSHL_CHAIN_STOP       2'h0
`define MSHL_CHAIN_STEP       2'h1
`define MSHL_CHAIN_CONT       2'h2

// Home-setting modes
`define MSHL_HOME_LEAVE       3'h1
`define MSHL_HOME_IDX_AFTER   3'h3
`define MSHL_HOME_IDX_IN      3'h4
`define MSHL_HOME_ENTER       3'h5
`define MSHL_HOME_HERE        3'h6
`define MSHL_HOME_LIMIT_IDX   3'h7

// Reset values
`define MSHL_RST_CHAIN        2'h0
`define MSHL_RST_HOME_MODE    3'h6

// Travel limit maximum setting
`define MSHL_LIMIT_MAX        22'h27FFFF

// Control register bits
`define MSHL_CTL_RUN_BIT      0
`define MSHL_CTL_HOME_BIT     1
`define MSHL_CTL_TEACH_BIT    2
`define MSHL_CTL_TEACH_END    3

// Output-force field: low byte value, next byte keep mask
`define MSHL_FORCE_KEEP_LSB   8

`endif

// *** rtl/mshl_core.v ***
// Purpose: Program channel chaining, output forcing, home return search and travel limit zone
// Assumes: Inputs synchronous to core_clk; register port with read data one cycle after read strobe
// Notes:   Summary of operation
// Summary of operation
// - With chaining option 0 processing ends once the selected channel finishes.
// - With chaining option 1 a finished channel arms the next number, later starts run it, channel select ignored.
// - With chaining option 2 channels run back to back in ascending order with no further start.
// - Digit n of the output-force command drives discrete output port n for ports seven to zero.
// - A force digit of 0 opens a port, 1 closes it and X leaves it unchanged.
// - Home mode 1 takes home where the axis leaves the home sensor region.
// - Home mode 3 takes home at the first index pulse after fully passing the home sensor region.
// - Home mode 4 takes home at the first index pulse after entering the home sensor region.
// - Home mode 5 takes home where the axis first enters the home sensor region.
// - Home mode 6 latches the present position at once and makes no motion.
// - Home mode 7 enters the limit sensor region, reverses, and takes home at the index pulse while reversing.
// - The span from travel-limit start upward to travel-limit end is forbidden.
// - The travel-limit start accepts whole counts from 0 through 2621439.
// - Teaching loads the present position into the travel-limit start setting.
// - Teaching is refused while the position sensor, absolute position or overspeed alarm is active.
`timescale 1ns/1ps
`include "mshl_map.vh"

module mshl_core #(
	parameter CH_W  = 4,
	parameter POS_W = 22
)(
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire [7:0]       reg_addr,
	input  wire [31:0]      reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [31:0]      reg_rdata,
	input  wire             start_req,
	input  wire [CH_W-1:0]  channel_select_input,
	input  wire             channel_done,
	output reg              channel_run,
	output reg  [CH_W-1:0]  channel_num,
	output reg  [7:0]       discrete_output_ports,
	input  wire [7:0]       port_function_level,
	input  wire [POS_W-1:0] present_position,
	input  wire             home_sensor,
	input  wire             index_pulse,
	input  wire             limit_sensor,
	output reg              home_move,
	output reg              home_reverse,
	output reg              home_found,
	input  wire             position_sensor_alarm,
	input  wire             absolute_position_alarm,
	input  wire             overspeed_alarm,
	output reg              limit_zone
);

	// Sequencer states
	localparam SQ_IDLE = 2'd0;
	localparam SQ_RUN  = 2'd1;
	localparam SQ_ARM  = 2'd2;
	// Homing states
	localparam HM_IDLE = 3'd0;
	localparam HM_SEEK = 3'd1;
	localparam HM_IN   = 3'd2;
	localparam HM_OUT  = 3'd3;
	localparam HM_REV  = 3'd4;

	reg  [1:0]       chain_q;
	reg  [2:0]       home_mode_q;
	reg  [POS_W-1:0] limit_start_q;
	reg  [POS_W-1:0] limit_end_q;
	reg  [POS_W-1:0] home_pos_q;
	reg  [7:0]       force_val_q;
	reg  [7:0]       force_keep_q;
	reg              force_en_q;
	reg              teach_refused_q;
	reg  [1:0]       sq_state_q;
	reg  [2:0]       hm_state_q;
	reg              home_prev_q;
	wire             alarm_any;
	wire             wr_chain;
	wire             wr_home;
	wire             wr_start;
	wire             wr_ctl;
	wire [POS_W-1:0] wdata_pos;

	assign alarm_any = position_sensor_alarm | absolute_position_alarm | overspeed_alarm;
	assign wr_chain  = reg_wr && (reg_addr == `MSHL_ADDR_CHAIN);
	assign wr_home   = reg_wr && (reg_addr == `MSHL_ADDR_HOME_MODE);
	assign wr_start  = reg_wr && (reg_addr == `MSHL_ADDR_LIMIT_START);
	assign wr_ctl    = reg_wr && (reg_addr == `MSHL_ADDR_CONTROL);
	assign wdata_pos = reg_wdata[POS_W-1:0];

	// Settings registers with range checks and teach
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			chain_q         <= `MSHL_RST_CHAIN;
			home_mode_q     <= `MSHL_RST_HOME_MODE;
			limit_start_q   <= {POS_W{1'b0}};
			limit_end_q     <= {POS_W{1'b0}};
			force_val_q     <= 8'h00;
			force_keep_q    <= 8'hFF;
			force_en_q      <= 1'b0;
			teach_refused_q <= 1'b0;
		end
		else
		begin
			if (wr_chain && reg_wdata[31:2] == 30'h0 && reg_wdata[1:0] != 2'h3)
				chain_q <= reg_wdata[1:0];
			if (wr_home && reg_wdata[31:3] == 29'h0 && reg_wdata[2:0] != 3'h0 && reg_wdata[2:0] != 3'h2)
				home_mode_q <= reg_wdata[2:0];
			if (wr_start && reg_wdata[31:POS_W] == {(32-POS_W){1'b0}} && wdata_pos <= `MSHL_LIMIT_MAX)
				limit_start_q <= wdata_pos;
			if (reg_wr && reg_addr == `MSHL_ADDR_LIMIT_END && reg_wdata[31:POS_W] == {(32-POS_W){1'b0}}
				&& wdata_pos <= `MSHL_LIMIT_MAX)
				limit_end_q <= wdata_pos;
			if (reg_wr && reg_addr == `MSHL_ADDR_FORCE)
			begin
				force_val_q  <= reg_wdata[7:0];
				force_keep_q <= reg_wdata[`MSHL_FORCE_KEEP_LSB+7:`MSHL_FORCE_KEEP_LSB];
				force_en_q   <= 1'b1;
			end
			if (wr_ctl && reg_wdata[`MSHL_CTL_TEACH_END])
				force_en_q <= 1'b0; // Release forcing back to normal functions
			if (wr_ctl && reg_wdata[`MSHL_CTL_TEACH_BIT])
			begin
				if (alarm_any)
					teach_refused_q <= 1'b1;
				else
				begin
					limit_start_q   <= present_position;
					teach_refused_q <= 1'b0;
				end
			end
		end
	end

	// Output forcing per port, held state when digit is X
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_port
			always @(posedge core_clk)
			begin
				if (sys_rst)
					discrete_output_ports[gi] <= 1'b0;
				else if (!force_en_q)
					discrete_output_ports[gi] <= port_function_level[gi];
				else if (!force_keep_q[gi])
					discrete_output_ports[gi] <= force_val_q[gi];
			end
		end
	endgenerate

	// Program channel sequencer
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sq_state_q  <= SQ_IDLE;
			channel_run <= 1'b0;
			channel_num <= {CH_W{1'b0}};
		end
		else
		begin
			case (sq_state_q)
				SQ_IDLE:
				begin
					if (start_req)
					begin
						channel_num <= channel_select_input;
						channel_run <= 1'b1;
						sq_state_q  <= SQ_RUN;
					end
				end
				SQ_RUN:
				begin
					if (channel_done)
					begin
						case (chain_q)
							`MSHL_CHAIN_STEP:
							begin
								channel_run <= 1'b0;
								channel_num <= channel_num + 1'b1;
								sq_state_q  <= SQ_ARM;
							end
							`MSHL_CHAIN_CONT:
								channel_num <= channel_num + 1'b1;
							default:
							begin
								channel_run <= 1'b0;
								sq_state_q  <= SQ_IDLE;
							end
						endcase
					end
				end
				SQ_ARM:
				begin
					if (chain_q != `MSHL_CHAIN_STEP)
						sq_state_q <= SQ_IDLE;
					else if (start_req)
					begin
						channel_run <= 1'b1;
						sq_state_q  <= SQ_RUN;
					end
				end
				default:
					sq_state_q <= SQ_IDLE;
			endcase
		end
	end

	// Home return search
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			hm_state_q   <= HM_IDLE;
			home_move    <= 1'b0;
			home_reverse <= 1'b0;
			home_found   <= 1'b0;
			home_pos_q   <= {POS_W{1'b0}};
			home_prev_q  <= 1'b0;
		end
		else
		begin
			home_prev_q <= home_sensor;
			home_found  <= 1'b0;
			case (hm_state_q)
				HM_IDLE:
				begin
					if (wr_ctl && reg_wdata[`MSHL_CTL_HOME_BIT])
					begin
						if (home_mode_q == `MSHL_HOME_HERE)
						begin
							home_pos_q <= present_position;
							home_found <= 1'b1;
						end
						else
						begin
							home_move  <= 1'b1;
							hm_state_q <= HM_SEEK;
						end
					end
				end
				HM_SEEK:
				begin
					if (home_mode_q == `MSHL_HOME_LIMIT_IDX)
					begin
						if (limit_sensor)
						begin
							home_reverse <= 1'b1;
							hm_state_q   <= HM_REV;
						end
					end
					else if (home_sensor && !home_prev_q)
					begin
						if (home_mode_q == `MSHL_HOME_ENTER)
						begin
							home_pos_q <= present_position;
							home_found <= 1'b1;
							home_move  <= 1'b0;
							hm_state_q <= HM_IDLE;
						end
						else
							hm_state_q <= HM_IN;
					end
				end
				HM_IN:
				begin
					if (home_mode_q == `MSHL_HOME_IDX_IN && index_pulse)
					begin
						home_pos_q <= present_position;
						home_found <= 1'b1;
						home_move  <= 1'b0;
						hm_state_q <= HM_IDLE;
					end
					else if (!home_sensor)
					begin
						if (home_mode_q == `MSHL_HOME_LEAVE)
						begin
							home_pos_q <= present_position;
							home_found <= 1'b1;
							home_move  <= 1'b0;
							hm_state_q <= HM_IDLE;
						end
						else if (home_mode_q == `MSHL_HOME_IDX_AFTER)
							hm_state_q <= HM_OUT;
					end
				end
				HM_OUT, HM_REV:
				begin
					if (index_pulse)
					begin
						home_pos_q   <= present_position;
						home_found   <= 1'b1;
						home_move    <= 1'b0;
						home_reverse <= 1'b0;
						hm_state_q   <= HM_IDLE;
					end
				end
				default:
					hm_state_q <= HM_IDLE;
			endcase
		end
	end

	// Forbidden zone from start setting upward to end setting, wrapping past the top
	always @(posedge core_clk)
	begin
		if (sys_rst)
			limit_zone <= 1'b0;
		else if (limit_start_q <= limit_end_q)
			limit_zone <= (present_position >= limit_start_q) && (present_position <= limit_end_q);
		else
			limit_zone <= (present_position >= limit_start_q) || (present_position <= limit_end_q);
	end

	// Read port, unmapped reads return zero
	always @(posedge core_clk)
	begin
		if (sys_rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`MSHL_ADDR_CHAIN:       reg_rdata <= {30'h0, chain_q};
				`MSHL_ADDR_HOME_MODE:   reg_rdata <= {29'h0, home_mode_q};
				`MSHL_ADDR_LIMIT_START: reg_rdata <= {{(32-POS_W){1'b0}}, limit_start_q};
				`MSHL_ADDR_LIMIT_END:   reg_rdata <= {{(32-POS_W){1'b0}}, limit_end_q};
				`MSHL_ADDR_FORCE:       reg_rdata <= {16'h0, force_keep_q, force_val_q};
				`MSHL_ADDR_STATUS:      reg_rdata <= {16'h0, channel_num[CH_W-1:0] & {CH_W{1'b1}},
					{(12-CH_W){1'b0}}, teach_refused_q, limit_zone, channel_run, home_move};
				`MSHL_ADDR_HOME_POS:    reg_rdata <= {{(32-POS_W){1'b0}}, home_pos_q};
				default:                reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end

endmodule // mshl_core

// *** tb/mshl_chk_assertions.sv ***
// Purpose: Port assertions for mshl_core
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every mshl_core instance
`timescale 1ns/1ps
module mshl_chk #(
	parameter CH_W = 4
)(
	input wire            core_clk,
	input wire            sys_rst,
	input wire [7:0]      reg_addr,
	input wire [31:0]     reg_wdata,
	input wire            reg_wr,
	input wire            reg_rd,
	input wire [31:0]     reg_rdata,
	input wire            start_req,
	input wire            channel_done,
	input wire            channel_run,
	input wire [CH_W-1:0] channel_num,
	input wire [7:0]      discrete_output_ports,
	input wire            home_move,
	input wire            home_reverse,
	input wire            home_found
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	found_pulse_a: assert property (home_found |=> !home_found || $past(reg_wr && reg_addr == 8'h14 && reg_wdata[1]))
		else $error("home found longer than one cycle");
	found_clear_a: assert property (home_found |-> !home_move)
		else $error("motion still requested at home");
	found_cause_a: assert property (home_found |-> $past(home_move) || $past(reg_wr && reg_addr == 8'h14))
		else $error("home found without search or command");
	rev_in_home_a: assert property (home_reverse |-> home_move)
		else $error("reverse outside a search");
	run_start_a: assert property ($rose(channel_run) |-> $past(start_req))
		else $error("channel started without start request");
	chain_step_a: assert property (channel_run && channel_done |=>
		!channel_run || channel_num == CH_W'($past(channel_num) + 1'b1))
		else $error("next channel number wrong");
	force_apply_a: assert property (reg_wr && reg_addr == 8'h10 |-> ##2
		((discrete_output_ports ^ $past(reg_wdata[7:0], 2)) & ~$past(reg_wdata[15:8], 2)) == 8'h00)
		else $error("forced port level wrong");
	force_keep_a: assert property (reg_wr && reg_addr == 8'h10 |-> ##2
		((discrete_output_ports ^ $past(discrete_output_ports)) & $past(reg_wdata[15:8], 2)) == 8'h00)
		else $error("kept port changed");
endmodule // mshl_chk

bind mshl_core mshl_chk #(.CH_W(CH_W)) u_chk (
	.core_clk              (core_clk),
	.sys_rst               (sys_rst),
	.reg_addr              (reg_addr),
	.reg_wdata             (reg_wdata),
	.reg_wr                (reg_wr),
	.reg_rd                (reg_rd),
	.reg_rdata             (reg_rdata),
	.start_req             (start_req),
	.channel_done          (channel_done),
	.channel_run           (channel_run),
	.channel_num           (channel_num),
	.discrete_output_ports (discrete_output_ports),
	.home_move             (home_move),
	.home_reverse          (home_reverse),
	.home_found            (home_found)
);

// *** tb/mshl_axis.sv ***
// Purpose: Channel and axis model facing mshl_core
// Assumes: Runs on core_clk
// Notes:   Ends a channel after a short run; sweeps sensors while homing
`timescale 1ns/1ps
module mshl_axis (
	input  wire core_clk,
	input  wire channel_run,
	input  wire home_move,
	input  wire home_reverse,
	output reg  channel_done = 1'b0,
	output wire home_sensor,
	output wire index_pulse,
	output wire limit_sensor
);
	reg [1:0] run_q  = 2'h0;
	reg [4:0] trav_q = 5'h00;
	// Channel finishes three cycles into its run
	always @(posedge core_clk)
	begin
		run_q        <= (channel_run && !channel_done) ? run_q + 2'h1 : 2'h0;
		channel_done <= channel_run && run_q == 2'h2;
	end
	// Travel count stands in for axis position during a search, counting back while reversing
	always @(posedge core_clk)
		trav_q <= home_move ? (home_reverse ? trav_q - 5'h01 : trav_q + 5'h01) : 5'h00;
	// Sensor region 4..7, index every fourth count, limit from 12
	assign home_sensor  = trav_q >= 5'h04 && trav_q <= 5'h07;
	assign index_pulse  = trav_q[1:0] == 2'h3;
	assign limit_sensor = trav_q >= 5'h0C;
endmodule // mshl_axis

// *** tb/mshl_core_tb.sv ***
// Purpose: Self-checking bench for mshl_core
// Assumes: 200 MHz clock, reset held 20 cycles
// Notes:   Reads are noted in a queue and checked by a monitor
`timescale 1ns/1ps
`include "mshl_map.vh"
module mshl_core_tb;
	localparam [17:0] MODES = {3'h6, 3'h7, 3'h5, 3'h4, 3'h3, 3'h1};
	// Cycles from search command to home found per mode, for the axis model's sensor layout
	localparam [29:0] WAITS = {5'h00, 5'h10, 5'h05, 5'h08, 5'h0C, 5'h09};
	reg         core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, start_req = 1'b0;
	reg  [7:0]  reg_addr = 8'h00, port_function_level = 8'h00;
	reg  [31:0] reg_wdata = 32'h0, seed = 32'h4C;
	reg  [3:0]  channel_select_input = 4'h0;
	reg  [21:0] present_position = 22'h0;
	reg         position_sensor_alarm = 1'b0, absolute_position_alarm = 1'b0, overspeed_alarm = 1'b0;
	reg         rd_d = 1'b0;
	reg  [31:0] exp_q[$], msk_q[$];
	integer     err_total = 0, compares = 0, cyc = 0, i, n;
	wire [31:0] reg_rdata;
	wire [3:0]  channel_num;
	wire [7:0]  discrete_output_ports;
	wire        channel_done, channel_run, home_sensor, index_pulse, limit_sensor;
	wire        home_move, home_reverse, home_found, limit_zone;
	mshl_core u_dut (.*);
	mshl_axis u_axis (.*);
	always #2.5 core_clk = ~core_clk;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp)
			begin
				err_total = err_total + 1;
				$display("mismatch %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge core_clk);
			reg_wr <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [31:0] m);
		begin
			exp_q.push_back(e);
			msk_q.push_back(m);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task go;
		begin
			start_req <= 1'b1;
			@(posedge core_clk);
			start_req <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task print_verdict;
		begin
			if (err_total == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Oldest noted read against returned data, plus hang guard
	always @(posedge core_clk)
	begin
		rd_d <= reg_rd;
		if (rd_d)
			chk("read", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
		cyc = cyc + 1;
		if (cyc == 3000)
		begin
			err_total = err_total + 1;
			print_verdict;
		end
	end
	// Main sequence
	initial
	begin
		seed = xs(seed);
		port_function_level <= seed[7:0];
		seed = xs(seed);
		present_position <= seed[21:0] & 22'h1FFFFF;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(`MSHL_ADDR_CHAIN, 32'h0, 32'h3);
		rd(`MSHL_ADDR_HOME_MODE, 32'h6, 32'h7);
		wr(`MSHL_ADDR_CHAIN, 32'h3);
		wr(`MSHL_ADDR_HOME_MODE, 32'h2);
		wr(`MSHL_ADDR_LIMIT_START, 32'h27FFFF);
		wr(`MSHL_ADDR_LIMIT_START, 32'h280000);
		rd(`MSHL_ADDR_CHAIN, 32'h0, 32'h3);
		rd(`MSHL_ADDR_HOME_MODE, 32'h6, 32'h7);
		rd(`MSHL_ADDR_LIMIT_START, 32'h27FFFF, 32'h3FFFFF);
		// Teach refused under each alarm, then accepted
		for (i = 0; i < 3; i = i + 1)
		begin
			{position_sensor_alarm, absolute_position_alarm, overspeed_alarm} <= 3'h1 << i;
			wr(`MSHL_ADDR_CONTROL, 32'h4);
			rd(`MSHL_ADDR_STATUS, 32'h8, 32'h8);
			rd(`MSHL_ADDR_LIMIT_START, 32'h27FFFF, 32'h3FFFFF);
		end
		{position_sensor_alarm, absolute_position_alarm, overspeed_alarm} <= 3'h0;
		wr(`MSHL_ADDR_CONTROL, 32'h4);
		rd(`MSHL_ADDR_LIMIT_START, {10'h0, present_position}, 32'h3FFFFF);
		rd(`MSHL_ADDR_STATUS, 32'h0, 32'h8);
		// Zone edges around 10..20
		wr(`MSHL_ADDR_LIMIT_START, 32'hA);
		wr(`MSHL_ADDR_LIMIT_END, 32'h14);
		for (i = 9; i < 22; i = i + 1)
		begin
			present_position <= i[21:0];
			repeat (2) @(posedge core_clk);
			rd(`MSHL_ADDR_STATUS, {29'h0, i >= 10 && i <= 20, 2'h0}, 32'h4);
		end
		// Force, then force again keeping the first nibble, then release
		wr(`MSHL_ADDR_FORCE, 32'hF00A);
		repeat (2) @(posedge core_clk);
		chk("ports", {24'h0, discrete_output_ports}, {24'h0, port_function_level[7:4], 4'hA});
		wr(`MSHL_ADDR_FORCE, 32'h0F50);
		repeat (2) @(posedge core_clk);
		chk("ports", {24'h0, discrete_output_ports}, 32'h5A);
		wr(`MSHL_ADDR_CONTROL, 32'h8);
		repeat (2) @(posedge core_clk);
		chk("ports", {24'h0, discrete_output_ports}, {24'h0, port_function_level});
		// Every home mode, ending with the latch-in-place mode
		for (i = 0; i < 6; i = i + 1)
		begin
			wr(`MSHL_ADDR_HOME_MODE, {29'h0, MODES[i*3 +: 3]});
			wr(`MSHL_ADDR_CONTROL, 32'h2);
			n = 0;
			while (home_found !== 1'b1 && n < 40)
			begin
				@(posedge core_clk);
				n = n + 1;
			end
			chk("found", {31'h0, home_found}, 32'h1);
			chk("wait", n, {27'h0, WAITS[i*5 +: 5]});
			repeat (2) @(posedge core_clk);
		end
		rd(`MSHL_ADDR_HOME_POS, 32'h15, 32'h3FFFFF);
		// Step, continuous and stop chaining
		wr(`MSHL_ADDR_CHAIN, 32'h1);
		channel_select_input <= 4'h3;
		go;
		repeat (8) @(posedge core_clk);
		rd(`MSHL_ADDR_STATUS, 32'h4000, 32'hF002);
		channel_select_input <= 4'h9;
		go;
		rd(`MSHL_ADDR_STATUS, 32'h4002, 32'hF002);
		repeat (8) @(posedge core_clk);
		wr(`MSHL_ADDR_CHAIN, 32'h2);
		channel_select_input <= 4'hF;
		go;
		repeat (12) @(posedge core_clk);
		rd(`MSHL_ADDR_STATUS, 32'h2002, 32'hF002);
		wr(`MSHL_ADDR_CHAIN, 32'h0);
		repeat (8) @(posedge core_clk);
		rd(`MSHL_ADDR_STATUS, 32'h3000, 32'hF002);
		repeat (4) @(posedge core_clk);
		print_verdict;
	end
endmodule // mshl_core_tb
